// ==== verilog/pcp_defs.svh ====
// Named constants for the six-channel power switch control and protection block.
// Assumes inclusion by bare name from the package and from every design module.
`ifndef PCP_DEFS_SVH
`define PCP_DEFS_SVH

// ==========================================================
// Channel counts and register widths
`define PCP_NCH 6
`define PCP_NDYN 5
`define PCP_NLAMP 3
`define PCP_OUT_W 6
`define PCP_LAMP_W 4
`define PCP_OUT_RST 6'h00
`define PCP_LAMP_RST 4'h0

// ==========================================================
// Serial frame layout (eight bits, first bit is bit 7)
`define PCP_FRAME_W 8
`define PCP_WR_BIT 7
`define PCP_RB_BIT 6
`define PCP_SEL_HI 6
`define PCP_SEL_LO 4
`define PCP_SEL_LAMP 3'h5
`define PCP_SEL_HARDWARE_COMMAND 3'h6
`define PCP_COMB_BIT 3
`define PCP_CTL_BIT 0
`define PCP_FRAME_BITS 4'h8
`define PCP_CLR_EDGE 4'h2
`define PCP_CNT_W 4

// ==========================================================
// Layout of the synchroniser bank
`define PCP_SYNC_W 27
`define PCP_SP_CS 0
`define PCP_SP_SCLK 1
`define PCP_SP_MOSI 2
`define PCP_SP_EXT 3
`define PCP_SP_OT 9
`define PCP_SP_HY 15
`define PCP_SP_DY 21
`define PCP_SP_GND 26

`endif

// ==== verilog/pcp_pkg.sv ====
// Types shared by the power switch control and protection modules.
// Assumes pcp_defs.svh is on the include path.
`include "pcp_defs.svh"

package pcp_pkg;

   // ==========================================================
   // Answer selected for the next frame
   typedef enum logic [1:0] {
      PCP_ANS_DIAG,
      PCP_ANS_OUT,
      PCP_ANS_LAMP
   } pcp_ans_e;

   // ==========================================================
   // Synchroniser state
   typedef struct packed {
      logic [`PCP_SYNC_W-1:0] stage1;
      logic [`PCP_SYNC_W-1:0] stage2;
   } pcp_sync_s;

   // ==========================================================
   // Serial frame engine state
   typedef struct packed {
      logic sclk_d;
      logic cs_d;
      logic [`PCP_CNT_W-1:0] count;
      logic [`PCP_FRAME_W-1:0] shift_in;
      logic [`PCP_FRAME_W-1:0] shift_out;
      logic [`PCP_FRAME_W-1:0] rx_byte;
      logic done;
      logic start;
      logic clr_pulse;
      logic miso;
      logic miso_oe;
   } pcp_spi_s;

   // ==========================================================
   // Control and protection state
   typedef struct packed {
      logic [`PCP_OUT_W-1:0] out_bits;
      logic [`PCP_LAMP_W-1:0] lamp;
      logic [`PCP_NCH-1:0] ot_latch;
      logic [`PCP_NCH-1:0] err;
      logic [`PCP_NCH-1:0] drive;
      logic [`PCP_NLAMP-1:0] led_mode;
      pcp_ans_e answer;
      logic diag_frame;
   } pcp_ctrl_s;

endpackage

// ==== verilog/pcp_sync.sv ====
// Two-stage synchroniser bank for every asynchronous pin of the block.
// Assumes one system clock; the first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
`include "pcp_defs.svh"

module pcp_sync
   import pcp_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [`PCP_SYNC_W-1:0] async_in,
   output logic [`PCP_SYNC_W-1:0] sync_out
);

   // ==========================================================
   // State
   pcp_sync_s state;
   pcp_sync_s next_state;

   always_comb begin
      next_state = state;
      next_state.stage1 = async_in;
      next_state.stage2 = state.stage1;
   end

   // Chip select idles high so reset value keeps the serial side inactive
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state.stage1 <= `PCP_SYNC_W'(1);
         state.stage2 <= `PCP_SYNC_W'(1);
      end else begin
         state <= next_state;
      end
   end

   assign sync_out = state.stage2;

endmodule
`default_nettype wire

// ==== verilog/pcp_spi_frame.sv ====
// Eight-bit serial frame engine: samples data on rising serial clock,
// shifts the answer out on falling serial clock, most significant bit first.
// Assumes synchronised pins and a serial clock at most one eighth of clock.
`timescale 1ns/1ps
`default_nettype none
`include "pcp_defs.svh"

module pcp_spi_frame
   import pcp_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic cs_n_s,
   input wire logic sclk_s,
   input wire logic mosi_s,
   input wire logic [`PCP_FRAME_W-1:0] tx_byte,
   output logic [`PCP_FRAME_W-1:0] rx_byte,
   output logic frame_done,
   output logic frame_start,
   output logic clr_pulse,
   output logic miso,
   output logic miso_oe
);

   // ==========================================================
   // State
   pcp_spi_s state;
   pcp_spi_s next_state;
   logic rise;
   logic fall;
   logic cs_fall;
   logic cs_rise;

   always_comb begin
      rise = sclk_s & ~state.sclk_d;
      fall = ~sclk_s & state.sclk_d;
      cs_fall = ~cs_n_s & state.cs_d;
      cs_rise = cs_n_s & ~state.cs_d;
      next_state = state;
      next_state.sclk_d = sclk_s;
      next_state.cs_d = cs_n_s;
      next_state.done = 1'b0;
      next_state.start = 1'b0;
      next_state.clr_pulse = 1'b0;
      next_state.miso_oe = ~cs_n_s;
      if (cs_fall) begin
         next_state.count = '0;
         next_state.shift_out = tx_byte;
         next_state.miso = tx_byte[`PCP_FRAME_W-1];
         next_state.start = 1'b1;
      end else if (!cs_n_s) begin
         if (rise) begin
            next_state.shift_in = {state.shift_in[`PCP_FRAME_W-2:0], mosi_s};
            next_state.count = state.count + `PCP_CNT_W'(1);
            // Clear point falls between second and third rising edge
            if (state.count + `PCP_CNT_W'(1) == `PCP_CLR_EDGE) begin
               next_state.clr_pulse = 1'b1;
            end
         end
         if (fall) begin
            next_state.shift_out = {state.shift_out[`PCP_FRAME_W-2:0], 1'b0};
            next_state.miso = state.shift_out[`PCP_FRAME_W-2];
         end
      end
      // Frames are dropped unless their bit count, modulo 16, is eight
      if (cs_rise && state.count == `PCP_FRAME_BITS) begin
         next_state.rx_byte = state.shift_in;
         next_state.done = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state <= '0;
         state.sclk_d <= 1'b0;
         state.cs_d <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign rx_byte = state.rx_byte;
   assign frame_done = state.done;
   assign frame_start = state.start;
   assign clr_pulse = state.clr_pulse;
   assign miso = state.miso;
   assign miso_oe = state.miso_oe;

endmodule
`default_nettype wire

// ==== verilog/pcp_power_ctrl.sv ====
// Control and protection logic of a six-channel high-side power switch,
// reached over the serial frame port.
// Assumes protection detector levels arrive from analog comparators,
// asynchronous to clock, and are synchronised here.
//
// Functional notes
// - Each of six channels has a read/write on bit: 0 off, 1 on.
// - Lamp configuration sits at select 1-0-1 with combine select in bit 3, lamp bits 2..0.
// - Each channel command joins its external drive with its on bit by OR or AND.
// - Lamp bits of channels 2..0 choose bulb mode (0) or LED mode (1).
// - A per-channel over-temperature trip forces the channel off and sets a held latch.
// - A latched channel returns only once cooled by the hysteresis and cleared by command.
// - One clear-thermal-latch command clears the latches of all cooled channels together.
// - Channels 0..4 switch off while their dynamic temperature detector trips.
// - Dynamic shutdown sets the fault flag; reading clears it; it sets again if still tripped.
// - Loss of device ground forces all channels off.
// - The hardware command register at select 1-1-0 is write-only; bit 0 clears latches.
// - Fault flags hold until sent in the diagnosis word, cleared after the second clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "pcp_defs.svh"

module pcp_power_ctrl
   import pcp_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   input wire logic [`PCP_NCH-1:0] external_drive_signal,
   input wire logic [`PCP_NCH-1:0] over_temp_trip,
   input wire logic [`PCP_NCH-1:0] temp_cooled,
   input wire logic [`PCP_NDYN-1:0] dyn_temp_trip,
   input wire logic ground_lost,
   output logic [`PCP_NCH-1:0] channel_drive,
   output logic [`PCP_NLAMP-1:0] lamp_type_bit,
   output logic [`PCP_NCH-1:0] fault_flag
);

   // ==========================================================
   // Pin synchronisation
   logic [`PCP_SYNC_W-1:0] pins_async;
   logic [`PCP_SYNC_W-1:0] pins;

   assign pins_async = {ground_lost, dyn_temp_trip, temp_cooled, over_temp_trip,
                        external_drive_signal, spi_mosi, spi_sclk, spi_cs_n};

   pcp_sync u_sync (
      .clock(clock),
      .nrst(nrst),
      .async_in(pins_async),
      .sync_out(pins)
   );

   logic cs_n_s;
   logic sclk_s;
   logic mosi_s;
   logic [`PCP_NCH-1:0] ext_s;
   logic [`PCP_NCH-1:0] ot_s;
   logic [`PCP_NCH-1:0] cool_s;
   logic [`PCP_NDYN-1:0] dyn_s;
   logic gnd_s;

   assign cs_n_s = pins[`PCP_SP_CS];
   assign sclk_s = pins[`PCP_SP_SCLK];
   assign mosi_s = pins[`PCP_SP_MOSI];
   assign ext_s = pins[`PCP_SP_EXT +: `PCP_NCH];
   assign ot_s = pins[`PCP_SP_OT +: `PCP_NCH];
   assign cool_s = pins[`PCP_SP_HY +: `PCP_NCH];
   assign dyn_s = pins[`PCP_SP_DY +: `PCP_NDYN];
   assign gnd_s = pins[`PCP_SP_GND];

   // ==========================================================
   // Serial frame engine
   logic [`PCP_FRAME_W-1:0] tx_byte;
   logic [`PCP_FRAME_W-1:0] rx_byte;
   logic frame_done;
   logic frame_start;
   logic clr_pulse;
   logic miso_q;
   logic miso_oe_q;

   pcp_spi_frame u_spi (
      .clock(clock),
      .nrst(nrst),
      .cs_n_s(cs_n_s),
      .sclk_s(sclk_s),
      .mosi_s(mosi_s),
      .tx_byte(tx_byte),
      .rx_byte(rx_byte),
      .frame_done(frame_done),
      .frame_start(frame_start),
      .clr_pulse(clr_pulse),
      .miso(miso_q),
      .miso_oe(miso_oe_q)
   );

   // ==========================================================
   // Helpers
   function automatic logic [`PCP_NCH-1:0] combine(
      input logic [`PCP_NCH-1:0] ext,
      input logic [`PCP_NCH-1:0] on_bits,
      input logic and_mode
   );
      logic [`PCP_NCH-1:0] res;
      res = and_mode ? (ext & on_bits) : (ext | on_bits);
      return res;
   endfunction

   function automatic logic [`PCP_NCH-1:0] widen_dyn(input logic [`PCP_NDYN-1:0] d);
      logic [`PCP_NCH-1:0] res;
      res = {{(`PCP_NCH-`PCP_NDYN){1'b0}}, d}; // Channel 5 has no dynamic sensor
      return res;
   endfunction

   // ==========================================================
   // State
   pcp_ctrl_s state;
   pcp_ctrl_s next_state;

   // Answer shown on the next frame; register reads are one frame late
   always_comb begin
      case (state.answer)
         PCP_ANS_OUT: tx_byte = {{(`PCP_FRAME_W-`PCP_OUT_W){1'b0}}, state.out_bits};
         PCP_ANS_LAMP: tx_byte = {{(`PCP_FRAME_W-`PCP_LAMP_W){1'b0}}, state.lamp};
         PCP_ANS_DIAG: tx_byte = {{(`PCP_FRAME_W-`PCP_NCH){1'b0}}, state.err};
         default: tx_byte = {{(`PCP_FRAME_W-`PCP_NCH){1'b0}}, state.err};
      endcase
   end

   // ==========================================================
   // Command decode
   logic is_write;
   logic sel_out;
   logic sel_lamp;
   logic sel_hardware_command;
   logic ctl_cmd;

   always_comb begin
      is_write = rx_byte[`PCP_WR_BIT];
      sel_out = ~rx_byte[`PCP_RB_BIT];
      sel_lamp = rx_byte[`PCP_SEL_HI:`PCP_SEL_LO] == `PCP_SEL_LAMP;
      sel_hardware_command = rx_byte[`PCP_SEL_HI:`PCP_SEL_LO] == `PCP_SEL_HARDWARE_COMMAND;
      ctl_cmd = frame_done & is_write & sel_hardware_command & rx_byte[`PCP_CTL_BIT];
   end

   // ==========================================================
   // Next state
   logic [`PCP_NCH-1:0] dyn_w;
   logic [`PCP_NCH-1:0] cmd;
   logic [`PCP_NCH-1:0] err_clr;

   always_comb begin
      next_state = state;
      dyn_w = widen_dyn(dyn_s);
      // Register writes
      if (frame_done && is_write) begin
         if (sel_out) begin
            next_state.out_bits = rx_byte[`PCP_OUT_W-1:0];
         end else if (sel_lamp) begin
            next_state.lamp = rx_byte[`PCP_LAMP_W-1:0];
         end
      end
      // Choice of answer for the next frame; a write of the hardware
      // command register selects the diagnosis answer, it reads back nothing
      if (frame_done) begin
         if (!is_write && sel_out) begin
            next_state.answer = PCP_ANS_OUT;
         end else if (!is_write && sel_lamp) begin
            next_state.answer = PCP_ANS_LAMP;
         end else begin
            next_state.answer = PCP_ANS_DIAG;
         end
      end
      if (frame_start) begin
         next_state.diag_frame = state.answer == PCP_ANS_DIAG;
      end
      // Thermal latch: trip sets, command clears only cooled channels,
      // and a trip in the clearing cycle wins
      for (int i = 0; i < `PCP_NCH; i++) begin
         if (ot_s[i]) begin
            next_state.ot_latch[i] = 1'b1;
         end else if (ctl_cmd && cool_s[i]) begin
            next_state.ot_latch[i] = 1'b0;
         end
      end
      // Fault flags clear when carried in a diagnosis word; a pending
      // cause sets them again in the same cycle
      err_clr = (clr_pulse && state.diag_frame) ? '1 : '0;
      next_state.err = (state.err & ~err_clr) | dyn_w | state.ot_latch;
      // Switch command and protection gating
      cmd = combine(ext_s, state.out_bits, state.lamp[`PCP_COMB_BIT]);
      cmd = cmd & ~state.ot_latch & ~ot_s;
      cmd = cmd & ~dyn_w;
      if (gnd_s) begin
         cmd = '0;
      end
      next_state.drive = cmd;
      next_state.led_mode = state.lamp[`PCP_NLAMP-1:0];
   end

   // Thermal latches reset clear; a detector still tripped re-sets them
   // on the third edge, which stands in for holding through supply loss
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state.out_bits <= `PCP_OUT_RST;
         state.lamp <= `PCP_LAMP_RST;
         state.ot_latch <= '0;
         state.err <= '0;
         state.drive <= '0;
         state.led_mode <= '0;
         state.answer <= PCP_ANS_DIAG;
         state.diag_frame <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // Outputs
   assign channel_drive = state.drive;
   assign lamp_type_bit = state.led_mode;
   assign fault_flag = state.err;
   assign spi_miso = miso_q;
   assign spi_miso_oe = miso_oe_q;

endmodule
`default_nettype wire

// ==== test/pcp_power_ctrl_sva.sv ====
// Port-level checker for the power switch control block.
// Assumes one clock domain and pcp_defs.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "pcp_defs.svh"

module pcp_power_ctrl_sva (
   input wire logic clock,
   input wire logic nrst,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   input wire logic spi_miso,
   input wire logic spi_miso_oe,
   input wire logic [`PCP_NCH-1:0] external_drive_signal,
   input wire logic [`PCP_NCH-1:0] over_temp_trip,
   input wire logic [`PCP_NCH-1:0] temp_cooled,
   input wire logic [`PCP_NDYN-1:0] dyn_temp_trip,
   input wire logic ground_lost,
   input wire logic [`PCP_NCH-1:0] channel_drive,
   input wire logic [`PCP_NLAMP-1:0] lamp_type_bit,
   input wire logic [`PCP_NCH-1:0] fault_flag
);
   // ==========================================
   // Age since reset; $past must not look back into reset
   logic [2:0] age;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         age <= 3'h0;
      end else if (age != 3'h7) begin
         age <= age + 3'h1;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // ==========================================
   // Properties; three edges of pipe from pin to output
   property p_gnd_off;
      ground_lost[*4] |-> channel_drive == 6'h00;
   endproperty
   a_gnd_off: assert property (p_gnd_off) else $error("drive on in ground loss");
   property p_ot_off;
      (age == 3'h7) |-> (channel_drive & over_temp_trip & $past(over_temp_trip)
         & $past(over_temp_trip, 2) & $past(over_temp_trip, 3)) == 6'h00;
   endproperty
   a_ot_off: assert property (p_ot_off) else $error("drive on in over temp");
   property p_dyn_off;
      (age == 3'h7) |-> (channel_drive[4:0] & dyn_temp_trip & $past(dyn_temp_trip)
         & $past(dyn_temp_trip, 2) & $past(dyn_temp_trip, 3)) == 5'h00;
   endproperty
   a_dyn_off: assert property (p_dyn_off) else $error("drive on in dyn trip");
   property p_dyn_flag;
      (age == 3'h7) |-> (~fault_flag[4:0] & dyn_temp_trip & $past(dyn_temp_trip)
         & $past(dyn_temp_trip, 2) & $past(dyn_temp_trip, 3)) == 5'h00;
   endproperty
   a_dyn_flag: assert property (p_dyn_flag) else $error("flag low in dyn trip");
   property p_oe_on;
      (!spi_cs_n)[*4] |-> spi_miso_oe;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("miso not driven in frame");
   property p_oe_off;
      spi_cs_n[*4] |-> !spi_miso_oe;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("miso driven outside frame");
   property p_lamp_hold;
      (!spi_cs_n)[*6] |-> $stable(lamp_type_bit);
   endproperty
   a_lamp_hold: assert property (p_lamp_hold) else $error("lamp bits moved in frame");
   property p_miso_hold;
      spi_sclk[*6] |-> $stable(spi_miso);
   endproperty
   a_miso_hold: assert property (p_miso_hold) else $error("miso moved with clock high");
   // Flags only drop at the clear point of a frame, so six idle samples of
   // chip select cover the sync and clear-pulse pipe ahead of the flag
   property p_flag_hold;
      spi_cs_n[*6] ##0 (age == 3'h7) |-> ($past(fault_flag) & ~fault_flag) == 6'h00;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag cleared outside frame");
   c_frame: cover property ($fell(spi_cs_n));
   c_gnd: cover property (ground_lost[*4]);
   c_flag: cover property (fault_flag[0] && fault_flag[4]);
endmodule

bind pcp_power_ctrl pcp_power_ctrl_sva u_sva (.clock(clock), .nrst(nrst),
   .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
   .spi_miso_oe(spi_miso_oe), .external_drive_signal(external_drive_signal),
   .over_temp_trip(over_temp_trip), .temp_cooled(temp_cooled),
   .dyn_temp_trip(dyn_temp_trip), .ground_lost(ground_lost), .channel_drive(channel_drive),
   .lamp_type_bit(lamp_type_bit), .fault_flag(fault_flag));
`default_nettype wire

// ==== test/pcp_host_model.sv ====
// Host controller model: sends frames of up to eight bits, most significant bit first.
// Assumes the device samples on serial clock rise; clock stands low outside frames.
`timescale 1ns/1ps
`default_nettype none

module pcp_host_model (
   input wire logic clock,
   output logic cs_n,
   output logic sclk,
   output logic mosi,
   input wire logic miso
);
   // ==========================================
   // Six clocks a level keeps the serial clock under one eighth of clock
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      @(negedge clock);
      cs_n = 1'b0;
      mosi = tx[7];
      repeat (6) @(negedge clock);
      for (int i = 7; i > 7 - nbits; i--) begin
         rx = {rx[6:0], miso};
         sclk = 1'b1;
         repeat (6) @(negedge clock);
         sclk = 1'b0;
         if (i > 0) begin
            mosi = tx[i - 1];
         end
         repeat (6) @(negedge clock);
      end
      cs_n = 1'b1;
      mosi = ~mosi;
      repeat (6) @(negedge clock);
   endtask
endmodule
`default_nettype wire

// ==== test/pcp_power_ctrl_bench.sv ====
// Self-checking bench for the power switch control block.
// Assumes the host model drives the serial pins; all else driven here.
`timescale 1ns/1ps
`default_nettype none

module pcp_power_ctrl_bench;
   logic clock, nrst, cs_n, sclk, mosi, miso, miso_oe, gnd;
   logic [5:0] ext, ot, cool, drive, flag;
   logic [4:0] dyn;
   logic [2:0] lamp;
   logic [7:0] rx, rx0;
   int fails, tests_run;
   pcp_power_ctrl dut (.clock(clock), .nrst(nrst), .spi_cs_n(cs_n), .spi_sclk(sclk),
      .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe), .external_drive_signal(ext),
      .over_temp_trip(ot), .temp_cooled(cool), .dyn_temp_trip(dyn), .ground_lost(gnd),
      .channel_drive(drive), .lamp_type_bit(lamp), .fault_flag(flag));
   pcp_host_model host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // ==========================================
   // Shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic conclude;
      $display("Compares %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Pipe is two edges plus one for the drive register
   task automatic st;
      repeat (8) @(negedge clock);
   endtask
   task automatic wr(input logic [7:0] d);
      host.xfer(d, 8, rx);
      st();
   endtask
   // Answer comes in the following frame; rx0 keeps the first frame's answer
   task automatic rd(input logic [7:0] req);
      host.xfer(req, 8, rx0);
      host.xfer(8'h00, 8, rx);
      st();
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset;
      chk(drive, 8'h00, "drive");
      chk(lamp, 8'h00, "lamp");
      rd(8'h50);
      chk(rx, 8'h00, "lamp_config");
      $display("reset test done");
   endtask
   task automatic t_or;
      ext = 6'h05;
      wr(8'haa);
      chk(drive, 8'h2f, "or drive");
      rd(8'h00);
      chk(rx, 8'h2a, "on bits");
      $display("or test done");
   endtask
   task automatic t_and;
      wr(8'hdd);
      chk(lamp, 8'h05, "lamp");
      chk(drive, 8'h00, "and drive");
      rd(8'h50);
      chk(rx, 8'h0d, "lamp_config");
      ext = 6'h3f;
      st();
      chk(drive, 8'h2a, "and drive");
      wr(8'hbf);
      $display("and test done");
   endtask
   task automatic t_thermal;
      ot = 6'h12;
      st();
      chk(drive, 8'h2d, "trip");
      ot = 6'h00;
      st();
      chk(drive, 8'h2d, "latched");
      chk(flag, 8'h12, "flag");
      wr(8'he1);
      cool = 6'h3f;
      st();
      chk(drive, 8'h2d, "hot clear");
      wr(8'he0);
      chk(drive, 8'h2d, "no clear");
      wr(8'he1);
      chk(drive, 8'h3f, "cleared");
      rd(8'h60);
      chk(rx0, 8'h12, "diag sent");
      chk(rx, 8'h00, "diag after");
      $display("thermal test done");
   endtask
   task automatic t_dyn;
      dyn = 5'h11;
      st();
      chk(drive, 8'h2e, "dyn off");
      rd(8'h60);
      chk(rx, 8'h11, "diag");
      chk(flag, 8'h11, "flag again");
      dyn = 5'h00;
      st();
      chk(drive, 8'h3f, "dyn back");
      chk(flag, 8'h11, "flag held");
      rd(8'h60);
      chk(flag, 8'h00, "flag read");
      $display("dyn test done");
   endtask
   task automatic t_gnd;
      gnd = 1'b1;
      st();
      chk(drive, 8'h00, "gnd off");
      gnd = 1'b0;
      st();
      chk(drive, 8'h3f, "gnd back");
      host.xfer(8'h80, 5, rx);
      st();
      chk(drive, 8'h3f, "short frame");
      wr(8'h80);
      chk(drive, 8'h00, "all off");
      $display("ground test done");
   endtask
   // ==========================================
   // Main sequence and watchdog
   initial begin
      fails = 0;
      tests_run = 0;
      nrst = 1'b0;
      gnd = 1'b0;
      ext = 6'h00;
      ot = 6'h00;
      cool = 6'h00;
      dyn = 5'h00;
      repeat (2) @(negedge clock);
      nrst = 1'b1;
      repeat (4) @(negedge clock);
      t_reset();
      t_or();
      t_and();
      t_thermal();
      t_dyn();
      t_gnd();
      conclude();
   end
   initial begin
      repeat (40000) @(posedge clock);
      fails++;
      conclude();
   end
endmodule
`default_nettype wire
